/* File: hdl/rtxc_pkg.sv */
package rtxc_pkg;

    localparam int WORD_W = 32;
    localparam int SEL_W  = 5;

    localparam logic [4:0] SEL_LSB = 5'h00;
    localparam logic [4:0] SEL_MSB = 5'h04;

    localparam logic [4:0] ADDR_POWER_CAL   = 5'h00;
    localparam logic [4:0] ADDR_LEVEL_REF   = 5'h01;
    localparam logic [4:0] ADDR_CONVERTER   = 5'h02;
    localparam logic [4:0] ADDR_MUX_RDBK    = 5'h03;
    localparam logic [4:0] ADDR_TEST_STATUS = 5'h04;
    localparam logic [4:0] ADDR_RAMP        = 5'h05;

    localparam int BIT_SECOND_CAL   = 12;
    localparam int BIT_FIRST_CAL    = 11;
    localparam int BIT_OSC_PWR      = 10;
    localparam int BIT_OSC_CAL      = 9;
    localparam int BIT_CONV_PWR     = 8;
    localparam int BIT_SECOND_PWR   = 7;
    localparam int BIT_FIRST_PWR    = 6;
    localparam int BIT_LO_PWR       = 5;
    localparam int LEVEL_REF_LSB    = 5;
    localparam int CONV_START_BIT   = 15;
    localparam int CONV_AVG_LSB     = 13;
    localparam int CONV_DIV_LSB     = 5;
    localparam int MUX_SEL_LSB      = 12;
    localparam int IO_LEVEL_BIT     = 11;
    localparam int RDBK_SEL_LSB     = 5;
    localparam int TEST_SEL_LSB     = 5;
    localparam int RAMP_ON_BIT      = 29;

    localparam logic [3:0]  MUX_RAMP_STATUS = 4'hf;
    localparam logic [7:0]  RST_LEVEL_REF   = 8'h00;
    localparam logic [7:0]  RST_CONV_DIV    = 8'h00;
    localparam logic [1:0]  RST_CONV_AVG    = 2'h0;
    localparam logic [3:0]  RST_MUX_SEL     = 4'h0;
    localparam logic [5:0]  RST_RDBK_SEL    = 6'h00;
    localparam logic [14:0] RST_TEST_SEL    = 15'h0000;

    typedef struct packed {
        logic oscillator_power_on;
        logic converter_power_on;
        logic second_output_power_on;
        logic first_output_power_on;
        logic local_osc_output_power_on;
    } rtxc_power_t;

    typedef struct packed {
        logic second_output_level_cal;
        logic first_output_level_cal;
        logic oscillator_calibrate;
    } rtxc_cal_t;

    typedef struct packed {
        logic [1:0] average_sel;
        logic [7:0] clock_div;
    } rtxc_conv_t;

endpackage

/* File: hdl/rtxc_regs.sv */
`timescale 1ns/100ps
`default_nettype none

module rtxc_regs (
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  word_valid,
    input  wire logic [31:0]           word_data,
    input  wire logic                  frac_lsb_written,
    input  wire logic                  modulator_reset_control,
    input  wire logic                  trigger_on_pin_enable,
    input  wire logic                  tx_data_pin,
    output rtxc_pkg::rtxc_power_t      power_ctl,
    output rtxc_pkg::rtxc_cal_t        cal_start,
    output logic [7:0]                 level_cal_target_code,
    output logic                       conv_start,
    output rtxc_pkg::rtxc_conv_t       conv_ctl,
    output logic [3:0]                 mux_select,
    output logic                       io_level_high,
    output logic [5:0]                 readback_select,
    output logic [14:0]                test_select,
    output logic                       analogue_test_pin_hiz,
    output logic                       ramp_status_on_mux,
    output logic                       ramp_enable,
    output logic                       ramp_run,
    output logic                       ramp_to_initial,
    output logic                       ramp_rearmed,
    output logic                       modulator_reset,
    output logic                       load_buffered
);

    logic [4:0]            sel;
    logic                  hit0;
    logic                  hit1;
    logic                  hit2;
    logic                  hit3;
    logic                  hit4;
    logic                  hit5;
    logic                  tx_meta;
    logic                  tx_sync;
    logic                  tx_prev;
    logic                  pin_stop;
    rtxc_pkg::rtxc_power_t next_power_ctl;
    rtxc_pkg::rtxc_cal_t   next_cal_start;
    logic [7:0]            next_level_cal_target_code;
    logic                  next_conv_start;
    rtxc_pkg::rtxc_conv_t  next_conv_ctl;
    logic [3:0]            next_mux_select;
    logic                  next_io_level_high;
    logic [5:0]            next_readback_select;
    logic [14:0]           next_test_select;
    logic                  next_ramp_enable;
    logic                  next_ramp_to_initial;
    logic                  next_ramp_rearmed;
    logic                  next_modulator_reset;
    logic                  next_load_buffered;

    assign sel  = word_data[rtxc_pkg::SEL_MSB:rtxc_pkg::SEL_LSB];
    assign hit0 = word_valid && (sel == rtxc_pkg::ADDR_POWER_CAL);
    assign hit1 = word_valid && (sel == rtxc_pkg::ADDR_LEVEL_REF);
    assign hit2 = word_valid && (sel == rtxc_pkg::ADDR_CONVERTER);
    assign hit3 = word_valid && (sel == rtxc_pkg::ADDR_MUX_RDBK);
    assign hit4 = word_valid && (sel == rtxc_pkg::ADDR_TEST_STATUS);
    assign hit5 = word_valid && (sel == rtxc_pkg::ADDR_RAMP);

    // The transmit-data pin is asynchronous, so only the second and third stages feed logic.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tx_meta <= 1'b0;
            tx_sync <= 1'b0;
            tx_prev <= 1'b0;
        end else begin
            tx_meta <= tx_data_pin;
            tx_sync <= tx_meta;
            tx_prev <= tx_sync;
        end
    end

    assign pin_stop = trigger_on_pin_enable && tx_prev && !tx_sync && ramp_enable;

    // The pin and ramp_enable both gate the ramp while pin triggering is on.
    assign ramp_run              = ramp_enable && (!trigger_on_pin_enable || tx_sync);
    assign analogue_test_pin_hiz = (test_select == 15'h0000);
    assign ramp_status_on_mux    = (mux_select == rtxc_pkg::MUX_RAMP_STATUS);

    always_comb begin
        next_power_ctl             = power_ctl;
        next_cal_start             = '0;
        next_level_cal_target_code = level_cal_target_code;
        next_conv_start            = 1'b0;
        next_conv_ctl              = conv_ctl;
        next_mux_select            = mux_select;
        next_io_level_high         = io_level_high;
        next_readback_select       = readback_select;
        next_test_select           = test_select;
        next_ramp_enable           = ramp_enable;
        next_ramp_to_initial       = pin_stop;
        next_ramp_rearmed          = ramp_rearmed;
        next_modulator_reset       = 1'b0;
        next_load_buffered         = 1'b0;
        if (hit0) begin
            // Both transmit bits set together is a host fault; the bits are passed as written.
            next_power_ctl.oscillator_power_on       = word_data[rtxc_pkg::BIT_OSC_PWR];
            next_power_ctl.converter_power_on        = word_data[rtxc_pkg::BIT_CONV_PWR];
            next_power_ctl.second_output_power_on    = word_data[rtxc_pkg::BIT_SECOND_PWR];
            next_power_ctl.first_output_power_on     = word_data[rtxc_pkg::BIT_FIRST_PWR];
            next_power_ctl.local_osc_output_power_on = word_data[rtxc_pkg::BIT_LO_PWR];
            next_cal_start.second_output_level_cal   = word_data[rtxc_pkg::BIT_SECOND_CAL];
            next_cal_start.first_output_level_cal    = word_data[rtxc_pkg::BIT_FIRST_CAL];
            next_cal_start.oscillator_calibrate      = word_data[rtxc_pkg::BIT_OSC_CAL];
        end
        if (hit1) begin
            next_level_cal_target_code = word_data[rtxc_pkg::LEVEL_REF_LSB +: 8];
        end
        if (hit2) begin
            next_conv_start           = word_data[rtxc_pkg::CONV_START_BIT];
            next_conv_ctl.average_sel = word_data[rtxc_pkg::CONV_AVG_LSB +: 2];
            next_conv_ctl.clock_div   = word_data[rtxc_pkg::CONV_DIV_LSB +: 8];
        end
        if (hit3) begin
            next_mux_select      = word_data[rtxc_pkg::MUX_SEL_LSB +: 4];
            next_io_level_high   = word_data[rtxc_pkg::IO_LEVEL_BIT];
            next_readback_select = word_data[rtxc_pkg::RDBK_SEL_LSB +: 6];
        end
        if (hit4) begin
            next_test_select = word_data[rtxc_pkg::TEST_SEL_LSB +: 15];
        end
        // Rearm is taken by a ramp start and set by the pin or a register 6 write; set wins.
        if (hit5 && word_data[rtxc_pkg::RAMP_ON_BIT]) begin
            next_ramp_rearmed = 1'b0;
        end
        if (pin_stop || frac_lsb_written) begin
            next_ramp_rearmed = 1'b1;
        end
        if (hit5) begin
            next_ramp_enable     = word_data[rtxc_pkg::RAMP_ON_BIT];
            next_load_buffered   = 1'b1;
            next_modulator_reset = !modulator_reset_control;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            power_ctl             <= '0;
            cal_start             <= '0;
            level_cal_target_code <= rtxc_pkg::RST_LEVEL_REF;
            conv_start            <= 1'b0;
            conv_ctl              <= {rtxc_pkg::RST_CONV_AVG, rtxc_pkg::RST_CONV_DIV};
            mux_select            <= rtxc_pkg::RST_MUX_SEL;
            io_level_high         <= 1'b0;
            readback_select       <= rtxc_pkg::RST_RDBK_SEL;
            test_select           <= rtxc_pkg::RST_TEST_SEL;
            ramp_enable           <= 1'b0;
            ramp_to_initial       <= 1'b0;
            ramp_rearmed          <= 1'b1;
            modulator_reset       <= 1'b0;
            load_buffered         <= 1'b0;
        end else begin
            power_ctl             <= next_power_ctl;
            cal_start             <= next_cal_start;
            level_cal_target_code <= next_level_cal_target_code;
            conv_start            <= next_conv_start;
            conv_ctl              <= next_conv_ctl;
            mux_select            <= next_mux_select;
            io_level_high         <= next_io_level_high;
            readback_select       <= next_readback_select;
            test_select           <= next_test_select;
            ramp_enable           <= next_ramp_enable;
            ramp_to_initial       <= next_ramp_to_initial;
            ramp_rearmed          <= next_ramp_rearmed;
            modulator_reset       <= next_modulator_reset;
            load_buffered         <= next_load_buffered;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_write0;
        word_valid && word_data[4:0] == 5'h00;
    endsequence

    sequence s_write5;
        word_valid && word_data[4:0] == 5'h05;
    endsequence

    sequence s_write2;
        word_valid && word_data[4:0] == 5'h02;
    endsequence

    sequence s_write3;
        word_valid && word_data[4:0] == 5'h03;
    endsequence

    sequence s_write4;
        word_valid && word_data[4:0] == 5'h04;
    endsequence

    property p_power_route;
        s_write0 |=> power_ctl == {$past(word_data[10]), $past(word_data[8]),
                                   $past(word_data[7]), $past(word_data[6]), $past(word_data[5])};
    endproperty
    a_power_route: assert property (p_power_route) else $error("power bits mismatch");

    property p_cal_pulse;
        s_write0 ##0 word_data[12] |=> cal_start.second_output_level_cal ##1
            !cal_start.second_output_level_cal || $past(word_valid);
    endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("second cal pulse wrong");

    property p_cal_only_on_write;
        cal_start.first_output_level_cal |-> $past(word_valid && word_data[4:0] == 5'h00
                                                  && word_data[11]);
    endproperty
    a_cal_only_on_write: assert property (p_cal_only_on_write) else $error("stray cal");

    property p_osc_cal;
        s_write0 |=> cal_start.oscillator_calibrate == $past(word_data[9]);
    endproperty
    a_osc_cal: assert property (p_osc_cal) else $error("osc cal mismatch");

    property p_level_hold;
        !(word_valid && word_data[4:0] == 5'h01) |=> $stable(level_cal_target_code);
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level code changed");

    property p_conv_start;
        word_valid && word_data[4:0] == 5'h02 && word_data[15] |=> conv_start ##1 !conv_start
            || $past(word_valid);
    endproperty
    a_conv_start: assert property (p_conv_start) else $error("conversion start wrong");

    property p_hiz;
        s_write4 |=> test_select == $past(word_data[19:5])
            && analogue_test_pin_hiz == ($past(word_data[19:5]) == 15'h0000);
    endproperty
    a_hiz: assert property (p_hiz) else $error("test pin float wrong");

    property p_ramp_enable;
        s_write5 |=> ramp_enable == $past(word_data[29]) && load_buffered;
    endproperty
    a_ramp_enable: assert property (p_ramp_enable) else $error("ramp enable wrong");

    property p_mod_reset;
        s_write5 ##0 !modulator_reset_control |=> modulator_reset;
    endproperty
    a_mod_reset: assert property (p_mod_reset) else $error("no modulator reset");

    property p_pin_stop;
        pin_stop |=> ramp_to_initial && ramp_rearmed;
    endproperty
    a_pin_stop: assert property (p_pin_stop) else $error("pin stop not handled");

    property p_sel_other;
        word_valid && word_data[4:0] > 5'h05 |=> $stable(power_ctl) && !load_buffered;
    endproperty
    a_sel_other: assert property (p_sel_other) else $error("unselected word stored");

    property p_conv_route;
        s_write2 |=> conv_ctl == {$past(word_data[14:13]), $past(word_data[12:5])};
    endproperty
    a_conv_route: assert property (p_conv_route) else $error("converter fields wrong");

    property p_mux_route;
        s_write3 |=> mux_select == $past(word_data[15:12])
            && io_level_high == $past(word_data[11])
            && readback_select == $past(word_data[10:5]);
    endproperty
    a_mux_route: assert property (p_mux_route) else $error("mux fields wrong");

    // The pin is two flops deep, so a fall at the first stage stops the run one edge later.
    property p_run_drop;
        trigger_on_pin_enable && ramp_enable && !tx_meta && tx_sync
            |=> !ramp_run || !trigger_on_pin_enable;
    endproperty
    a_run_drop: assert property (p_run_drop) else $error("ramp kept running");

    property p_load_only;
        load_buffered |-> $past(word_valid && word_data[4:0] == 5'h05);
    endproperty
    a_load_only: assert property (p_load_only) else $error("stray buffer load");

    property p_mod_reset_off;
        s_write5 ##0 modulator_reset_control |=> !modulator_reset;
    endproperty
    a_mod_reset_off: assert property (p_mod_reset_off) else $error("unwanted modulator reset");

    property p_frac_rearm;
        frac_lsb_written |=> ramp_rearmed;
    endproperty
    a_frac_rearm: assert property (p_frac_rearm) else $error("no rearm after frac write");

endmodule

`default_nettype wire

/* File: bench/rtxc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module rtxc_host_model (
    input  wire logic        ref_clk,
    output logic             word_valid,
    output logic [31:0]      word_data
);
    initial begin
        word_valid = 1'b0;
        word_data  = 32'h0000_0000;
    end

    // Words are built with reserved bits zero and never both transmit power bits.
    // A released data bus shows the inverse of the last word, not a stale copy.
    task automatic send(input logic [31:0] w);
        @(negedge ref_clk);
        word_valid = 1'b1;
        word_data  = w;
        @(negedge ref_clk);
        word_valid = 1'b0;
        word_data  = ~w;
    endtask
endmodule

`default_nettype wire

/* File: bench/radar_tx_control_registers_test.sv */
`timescale 1ns/100ps
`default_nettype none

module radar_tx_control_registers_test;
    logic                 ref_clk = 1'b0;
    logic                 sys_rst;
    logic                 word_valid;
    logic [31:0]          word_data;
    logic                 frac_lsb_written;
    logic                 modulator_reset_control;
    logic                 trigger_on_pin_enable;
    logic                 tx_data_pin;
    rtxc_pkg::rtxc_power_t power_ctl;
    rtxc_pkg::rtxc_cal_t   cal_start;
    rtxc_pkg::rtxc_conv_t  conv_ctl;
    logic [7:0]           level_cal_target_code;
    logic                 conv_start;
    logic                 io_level_high;
    logic                 analogue_test_pin_hiz;
    logic [3:0]           mux_select;
    logic [5:0]           readback_select;
    logic [14:0]          test_select;
    logic                 ramp_status_on_mux;
    logic                 ramp_enable;
    logic                 ramp_run;
    logic                 ramp_to_initial;
    logic                 ramp_rearmed;
    logic                 modulator_reset;
    logic                 load_buffered;
    int                   n_fail = 0;
    int                   num_checks = 0;
    int                   cycles = 0;

    always #2.5 ref_clk = ~ref_clk;

    rtxc_host_model i_host (.ref_clk(ref_clk), .word_valid(word_valid), .word_data(word_data));

    rtxc_regs i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .word_valid(word_valid), .word_data(word_data),
        .frac_lsb_written(frac_lsb_written), .modulator_reset_control(modulator_reset_control),
        .trigger_on_pin_enable(trigger_on_pin_enable), .tx_data_pin(tx_data_pin),
        .power_ctl(power_ctl), .cal_start(cal_start),
        .level_cal_target_code(level_cal_target_code), .conv_start(conv_start),
        .conv_ctl(conv_ctl), .mux_select(mux_select), .io_level_high(io_level_high),
        .readback_select(readback_select), .test_select(test_select),
        .analogue_test_pin_hiz(analogue_test_pin_hiz), .ramp_status_on_mux(ramp_status_on_mux),
        .ramp_enable(ramp_enable), .ramp_run(ramp_run), .ramp_to_initial(ramp_to_initial),
        .ramp_rearmed(ramp_rearmed), .modulator_reset(modulator_reset),
        .load_buffered(load_buffered)
    );

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // The ceiling is far above the roughly 42 cycles the sequence needs.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic t_reset;
        repeat (4) @(negedge ref_clk);
        chk(power_ctl, 32'h0, "power reset");
        chk(ramp_rearmed, 32'h1, "rearmed reset");
        chk(analogue_test_pin_hiz, 32'h1, "hiz reset");
        sys_rst = 1'b0;
    endtask

    task automatic t_power;
        logic [31:0] words [3] = '{32'h0000_1400, 32'h0000_0f60, 32'h0000_0080};
        logic [4:0]  pw [3]    = '{5'h10, 5'h1b, 5'h04};
        logic [2:0]  cl [3]    = '{3'h4, 3'h3, 3'h0};
        for (int i = 0; i < 3; i++) begin
            i_host.send(words[i]);
            chk(power_ctl, pw[i], "power");
            chk(cal_start, cl[i], "cal");
            @(negedge ref_clk);
            chk(cal_start, 32'h0, "cal pulse");
        end
    endtask

    task automatic t_fields;
        i_host.send(32'h0000_14a1);
        chk(level_cal_target_code, 32'ha5, "level code");
        i_host.send(32'h0000_c782);
        chk(conv_start, 32'h1, "conv start");
        chk(conv_ctl, 32'h23c, "conv ctl");
        @(negedge ref_clk);
        chk(conv_start, 32'h0, "conv pulse");
        i_host.send(32'h0000_fd43);
        chk(mux_select, 32'hf, "mux");
        chk(io_level_high, 32'h1, "io level");
        chk(readback_select, 32'h2a, "readback");
        chk(ramp_status_on_mux, 32'h1, "status on mux");
        i_host.send(32'h0002_4684);
        chk(test_select, 32'h1234, "test sel");
        chk(analogue_test_pin_hiz, 32'h0, "hiz off");
        i_host.send(32'h0000_0004);
        chk(analogue_test_pin_hiz, 32'h1, "hiz on");
        // Selects outside the bank must leave every field untouched.
        i_host.send(32'h0000_ffe6);
        i_host.send(32'h0000_001f);
        chk(power_ctl, 32'h04, "refused power");
        chk(level_cal_target_code, 32'ha5, "refused code");
    endtask

    task automatic t_ramp;
        i_host.send(32'h2000_0005);
        chk(ramp_enable, 32'h1, "ramp on");
        chk(load_buffered, 32'h1, "load");
        chk(modulator_reset, 32'h1, "sd reset");
        chk(ramp_rearmed, 32'h0, "not rearmed");
        modulator_reset_control = 1'b1;
        i_host.send(32'h0000_0005);
        chk(ramp_enable, 32'h0, "ramp off");
        chk(load_buffered, 32'h1, "load again");
        chk(modulator_reset, 32'h0, "no sd reset");
        @(negedge ref_clk);
        chk(load_buffered, 32'h0, "load pulse");
    endtask

    task automatic t_pin;
        int n;
        trigger_on_pin_enable = 1'b1;
        i_host.send(32'h2000_0005);
        chk(ramp_run, 32'h1, "run");
        tx_data_pin = 1'b0;
        n = 0;
        while (ramp_to_initial !== 1'b1 && n < 6) begin
            @(negedge ref_clk);
            n++;
        end
        chk(ramp_to_initial, 32'h1, "to initial");
        chk(ramp_rearmed, 32'h1, "pin rearm");
        chk(ramp_run, 32'h0, "pin stop");
        @(negedge ref_clk);
        chk(ramp_to_initial, 32'h0, "to initial pulse");
        i_host.send(32'h2000_0005);
        chk(ramp_rearmed, 32'h0, "armed again");
        frac_lsb_written = 1'b1;
        @(negedge ref_clk);
        frac_lsb_written = 1'b0;
        chk(ramp_rearmed, 32'h1, "frac rearm");
        trigger_on_pin_enable = 1'b0;
        #1;
        chk(ramp_run, 32'h1, "register run");
    endtask

    initial begin
        // The pin idles high and pin triggering stays off until its own scenario.
        sys_rst                 = 1'b1;
        frac_lsb_written        = 1'b0;
        modulator_reset_control = 1'b0;
        trigger_on_pin_enable   = 1'b0;
        tx_data_pin             = 1'b1;
        t_reset();
        t_power();
        t_fields();
        t_ramp();
        t_pin();
        summarize();
    end
endmodule

`default_nettype wire
